// file: rtl/spi_port_pkg.sv
// package for the serial port pin block: control fields, states, timing.
// assumes one 250 MHz clock and plain ports for all control bits.
package spi_port_pkg;
  // =====================================================================
  // control word layout (serial_control_register)
  // =====================================================================
  localparam int unsigned CTL_W          = 16;
  localparam int unsigned CTL_MASTER     = 0;
  localparam int unsigned CTL_CPOL       = 1;
  localparam int unsigned CTL_CPHA       = 2;
  localparam int unsigned CTL_ENABLE     = 3;
  localparam int unsigned CTL_OPEN_DRAIN = 4;
  localparam int unsigned CTL_SLV_OUT_DIS = 5;
  localparam int unsigned CTL_RATE_LSB   = 8;
  localparam int unsigned RATE_W         = 8;
  localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;

  // =====================================================================
  // word and flag pin sizes
  // =====================================================================
  localparam int unsigned WORD_W  = 8;
  localparam int unsigned CNT_W   = 4;
  localparam int unsigned FLAG_N  = 4;
  localparam logic [CNT_W-1:0] WORD_BITS = 4'h8;

  // flag pin modes: 0 general, 1 alternate (irq / timer), 2 slave select
  localparam int unsigned FMODE_W = 2;
  localparam logic [FMODE_W-1:0] FMODE_GPIO = 2'h0;
  localparam logic [FMODE_W-1:0] FMODE_ALT  = 2'h1;
  localparam logic [FMODE_W-1:0] FMODE_SEL  = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LEAD  = 4'h2,
    ST_SHIFT = 4'h4,
    ST_DONE  = 4'h8
  } xfer_state_t;

  // pin pair for a two-way line; oe_n low while driving
  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drv_t;
endpackage : spi_port_pkg

// file: rtl/spi_sync2.sv
// two-flop synchroniser for one asynchronous level.
// assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module spi_sync2 (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic async_i,
  input  wire logic rst_val_i,
  output logic      sync_o
);
  logic meta_ff;
  logic sync_ff;
  // =====================================================================
  // register chain; first flop feeds only the second
  // =====================================================================
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_ff <= rst_val_i;
      sync_ff <= rst_val_i;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule : spi_sync2

// file: rtl/spi_port.sv
// serial port pin logic: master clock generation, slave following,
// multimaster error, flag pins as selects.
// assumes pins arrive asynchronous; control bits come from plain ports.
`timescale 1ns/1ps
module spi_port (
  input  wire logic                               SYS_CLK_I,
  input  wire logic                               NRST_I,
  input  wire logic [spi_port_pkg::CTL_W-1:0]     CTL_I,
  input  wire logic [spi_port_pkg::WORD_W-1:0]    TX_DATA_I,
  input  wire logic                               TX_START_I,
  input  wire logic [spi_port_pkg::FLAG_N*2-1:0]  FLAG_MODE_I,
  input  wire logic [spi_port_pkg::FLAG_N-1:0]    FLAG_OUT_I,
  input  wire logic [spi_port_pkg::FLAG_N-1:0]    FLAG_DIR_I,
  input  wire logic [spi_port_pkg::FLAG_N-1:0]    SEL_ASSERT_I,
  input  wire logic                               TIMER_EXPIRED_I,
  input  wire logic                               SCLK_I,
  input  wire logic                               SLAVE_SELECT_I,
  input  wire logic                               DOUT_PIN_I,
  input  wire logic                               DIN_PIN_I,
  input  wire logic [spi_port_pkg::FLAG_N-1:0]    FLAG_I,
  output logic                                    SCLK_O,
  output logic                                    SCLK_OE_N_O,
  output logic                                    DOUT_PIN_O,
  output logic                                    DOUT_OE_N_O,
  output logic                                    DIN_PIN_O,
  output logic                                    DIN_OE_N_O,
  output logic [spi_port_pkg::FLAG_N-1:0]         FLAG_O,
  output logic [spi_port_pkg::FLAG_N-1:0]         FLAG_OE_N_O,
  output logic [spi_port_pkg::FLAG_N-1:0]         FLAG_IN_O,
  output logic                                    INT_REQ_O,
  output logic [spi_port_pkg::WORD_W-1:0]         RX_DATA_O,
  output logic                                    RX_VALID_O,
  output logic                                    BUSY_O,
  output logic                                    MM_ERROR_O
);
  // =====================================================================
  // state record
  // =====================================================================
  typedef struct packed {
    spi_port_pkg::xfer_state_t          st;
    logic [spi_port_pkg::RATE_W-1:0]    div;
    logic [spi_port_pkg::CNT_W-1:0]     bits;
    logic                               sclk;
    logic [spi_port_pkg::WORD_W-1:0]    tx_sh;
    logic [spi_port_pkg::WORD_W-1:0]    rx_sh;
    logic                               sclk_d;
    logic                               s_half;
    logic [spi_port_pkg::CNT_W-1:0]     s_bits;
    logic                               sout;
    logic                               sclk_o;
    logic                               sclk_oe_n;
    logic                               dout;
    logic                               dout_oe_n;
    logic                               din;
    logic                               din_oe_n;
    logic [spi_port_pkg::FLAG_N-1:0]    flag;
    logic [spi_port_pkg::FLAG_N-1:0]    flag_oe_n;
    logic [spi_port_pkg::FLAG_N-1:0]    flag_in;
    logic                               int_req;
    logic [spi_port_pkg::WORD_W-1:0]    rx_data;
    logic                               rx_valid;
    logic                               mm_err;
    logic                               busy;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic                            sclk_s;
  logic                            sel_s;
  logic                            dout_s;
  logic                            din_s;
  logic [spi_port_pkg::FLAG_N-1:0] flag_s;

  // =====================================================================
  // pin synchronisers; every pin is async to the system clock
  // =====================================================================
  spi_sync2 u_sync_sclk (.clk_i(SYS_CLK_I), .nrst_i(NRST_I),
    .async_i(SCLK_I), .rst_val_i(1'b1), .sync_o(sclk_s));
  spi_sync2 u_sync_sel (.clk_i(SYS_CLK_I), .nrst_i(NRST_I),
    .async_i(SLAVE_SELECT_I), .rst_val_i(1'b1), .sync_o(sel_s));
  spi_sync2 u_sync_dout (.clk_i(SYS_CLK_I), .nrst_i(NRST_I),
    .async_i(DOUT_PIN_I), .rst_val_i(1'b1), .sync_o(dout_s));
  spi_sync2 u_sync_din (.clk_i(SYS_CLK_I), .nrst_i(NRST_I),
    .async_i(DIN_PIN_I), .rst_val_i(1'b1), .sync_o(din_s));
  for (genvar g = 0; g < spi_port_pkg::FLAG_N; g++) begin : g_fsync
    spi_sync2 u_sync_flag (.clk_i(SYS_CLK_I), .nrst_i(NRST_I),
      .async_i(FLAG_I[g]), .rst_val_i(1'b1), .sync_o(flag_s[g]));
  end

  // =====================================================================
  // next-state logic
  // =====================================================================
  always_comb begin
    logic master;
    logic cpol;
    logic cpha;
    logic en;
    logic [spi_port_pkg::RATE_W-1:0] rate;
    logic tick;
    logic lead_e;
    logic trail_e;
    logic s_rise;
    logic s_fall;
    logic s_lead;
    logic s_trail;
    logic [spi_port_pkg::FMODE_W-1:0] fm;
    nxt_cur = cur_ff;
    master  = CTL_I[spi_port_pkg::CTL_MASTER];
    cpol    = CTL_I[spi_port_pkg::CTL_CPOL];
    cpha    = CTL_I[spi_port_pkg::CTL_CPHA];
    en      = CTL_I[spi_port_pkg::CTL_ENABLE];
    rate    = CTL_I[spi_port_pkg::CTL_RATE_LSB +: spi_port_pkg::RATE_W];
    tick    = (cur_ff.div == 8'h00);
    lead_e  = 1'b0;
    trail_e = 1'b0;
    nxt_cur.rx_valid = 1'b0;
    s_rise  = sclk_s & ~cur_ff.sclk_d;
    s_fall  = ~sclk_s & cur_ff.sclk_d;
    s_lead  = cpol ? s_fall : s_rise;
    s_trail = cpol ? s_rise : s_fall;
    nxt_cur.sclk_d = sclk_s;
    fm = 2'h0;

    // master clock generator; divider sets the half-bit time
    case (cur_ff.st)
      spi_port_pkg::ST_IDLE: begin
        nxt_cur.sclk = cpol;
        nxt_cur.div  = rate;
        if (en && master && TX_START_I && !cur_ff.mm_err) begin
          nxt_cur.tx_sh = TX_DATA_I;
          nxt_cur.bits  = spi_port_pkg::WORD_BITS;
          nxt_cur.st    = spi_port_pkg::ST_LEAD;
        end
      end
      spi_port_pkg::ST_LEAD: begin
        if (tick) begin
          nxt_cur.div = rate;
          nxt_cur.sclk = ~cur_ff.sclk;
          lead_e = 1'b1;
          nxt_cur.st = spi_port_pkg::ST_SHIFT;
        end else begin
          nxt_cur.div = cur_ff.div - 8'h01;
        end
      end
      spi_port_pkg::ST_SHIFT: begin
        if (tick) begin
          nxt_cur.div = rate;
          nxt_cur.sclk = ~cur_ff.sclk;
          trail_e = 1'b1;
          nxt_cur.bits = cur_ff.bits - 4'h1;
          if (cur_ff.bits == 4'h1) begin             // last bit of word
            nxt_cur.st = spi_port_pkg::ST_DONE;
          end else begin
            nxt_cur.st = spi_port_pkg::ST_LEAD;
          end
        end else begin
          nxt_cur.div = cur_ff.div - 8'h01;
        end
      end
      spi_port_pkg::ST_DONE: begin
        nxt_cur.rx_data  = cur_ff.rx_sh;
        nxt_cur.rx_valid = 1'b1;
        nxt_cur.st = spi_port_pkg::ST_IDLE;
      end
      default: nxt_cur.st = spi_port_pkg::ST_IDLE;
    endcase
    nxt_cur.busy = (nxt_cur.st != spi_port_pkg::ST_IDLE);

    // master shift/sample: opposite edges, phase picks which
    if (lead_e) begin
      if (cpha) begin
        nxt_cur.sout  = cur_ff.tx_sh[spi_port_pkg::WORD_W-1];
        nxt_cur.tx_sh = {cur_ff.tx_sh[spi_port_pkg::WORD_W-2:0], 1'b0};
      end else begin
        nxt_cur.rx_sh = {cur_ff.rx_sh[spi_port_pkg::WORD_W-2:0], din_s};
      end
    end
    if (trail_e) begin
      if (cpha) begin
        nxt_cur.rx_sh = {cur_ff.rx_sh[spi_port_pkg::WORD_W-2:0], din_s};
      end else begin
        nxt_cur.sout  = cur_ff.tx_sh[spi_port_pkg::WORD_W-2];
        nxt_cur.tx_sh = {cur_ff.tx_sh[spi_port_pkg::WORD_W-2:0], 1'b0};
      end
    end
    if (cur_ff.st == spi_port_pkg::ST_IDLE && master) begin
      nxt_cur.sout = cpha ? cur_ff.sout : TX_DATA_I[spi_port_pkg::WORD_W-1];
    end

    // slave: follow external clock only while selected
    if (!master) begin
      if (sel_s || !en) begin
        nxt_cur.s_bits = spi_port_pkg::WORD_BITS;
        nxt_cur.s_half = 1'b0;
        nxt_cur.tx_sh  = TX_DATA_I;
        nxt_cur.sout   = cpha ? 1'b0 : TX_DATA_I[spi_port_pkg::WORD_W-1];
      end else begin
        if ((cpha ? s_trail : s_lead)) begin
          nxt_cur.rx_sh = {cur_ff.rx_sh[spi_port_pkg::WORD_W-2:0], dout_s};
          nxt_cur.s_bits = cur_ff.s_bits - 4'h1;
          if (cur_ff.s_bits == 4'h1) begin
            nxt_cur.rx_data =
              {cur_ff.rx_sh[spi_port_pkg::WORD_W-2:0], dout_s};
            nxt_cur.rx_valid = 1'b1;
            nxt_cur.s_bits = spi_port_pkg::WORD_BITS;
          end
        end
        if ((cpha ? s_lead : s_trail)) begin
          nxt_cur.sout  = cpha ? cur_ff.tx_sh[spi_port_pkg::WORD_W-1]
                               : cur_ff.tx_sh[spi_port_pkg::WORD_W-2];
          nxt_cur.tx_sh = {cur_ff.tx_sh[spi_port_pkg::WORD_W-2:0], 1'b0};
        end
      end
    end

    // multimaster error is sticky until master mode is left
    if (master && en && !sel_s) begin
      nxt_cur.mm_err = 1'b1;
    end else if (!master) begin
      nxt_cur.mm_err = 1'b0;
    end

    // pin drivers; oe_n low means driven
    nxt_cur.sclk_o    = (master && en) ? cur_ff.sclk : 1'b1;
    nxt_cur.sclk_oe_n = ~(master && en);
    nxt_cur.dout      = cur_ff.sout;
    nxt_cur.dout_oe_n = ~(master && en);
    nxt_cur.din       = cur_ff.sout;
    nxt_cur.din_oe_n  = ~(!master && en && !sel_s &&
                          !CTL_I[spi_port_pkg::CTL_SLV_OUT_DIS]);
    if (CTL_I[spi_port_pkg::CTL_OPEN_DRAIN] && cur_ff.sout) begin
      nxt_cur.din_oe_n = 1'b1;                             // open drain high
    end

    // flag pin muxing
    nxt_cur.flag_in = flag_s;
    nxt_cur.int_req = (FLAG_MODE_I[1:0] == spi_port_pkg::FMODE_ALT)
                   & ~flag_s[0];
    for (int i = 0; i < spi_port_pkg::FLAG_N; i++) begin
      fm = FLAG_MODE_I[i*2 +: 2];
      nxt_cur.flag[i] = FLAG_OUT_I[i];
      nxt_cur.flag_oe_n[i] = ~FLAG_DIR_I[i];
      if (fm == spi_port_pkg::FMODE_SEL) begin
        nxt_cur.flag[i] = ~SEL_ASSERT_I[i];
        nxt_cur.flag_oe_n[i] = ~master;
      end else if (fm == spi_port_pkg::FMODE_ALT) begin
        if (i == 3) begin
          nxt_cur.flag[i] = TIMER_EXPIRED_I;
          nxt_cur.flag_oe_n[i] = 1'b0;
        end else begin
          nxt_cur.flag_oe_n[i] = 1'b1;
        end
      end
    end
  end

  // =====================================================================
  // state register; reset leaves every flag pin an input
  // =====================================================================
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      cur_ff <= '{st: spi_port_pkg::ST_IDLE, sclk_o: 1'b1, sclk_oe_n: 1'b1,
                  dout_oe_n: 1'b1, din_oe_n: 1'b1, sclk_d: 1'b1,
                  flag_oe_n: 4'hF,
                  s_bits: spi_port_pkg::WORD_BITS, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from the state record
  assign SCLK_O      = cur_ff.sclk_o;
  assign SCLK_OE_N_O = cur_ff.sclk_oe_n;
  assign DOUT_PIN_O  = cur_ff.dout;
  assign DOUT_OE_N_O = cur_ff.dout_oe_n;
  assign DIN_PIN_O   = cur_ff.din;
  assign DIN_OE_N_O  = cur_ff.din_oe_n;
  assign FLAG_O      = cur_ff.flag;
  assign FLAG_OE_N_O = cur_ff.flag_oe_n;
  assign FLAG_IN_O   = cur_ff.flag_in;
  assign INT_REQ_O   = cur_ff.int_req;
  assign RX_DATA_O   = cur_ff.rx_data;
  assign RX_VALID_O  = cur_ff.rx_valid;
  assign BUSY_O      = cur_ff.busy;
  assign MM_ERROR_O  = cur_ff.mm_err;
endmodule : spi_port

// file: tb/spi_port_checker.sv
// checker: clock, select and flag pin relations of the serial port.
// assumes it is bound into spi_port and sees only that module's ports.
`timescale 1ns/1ps
module spi_port_checker (
  input wire logic        SYS_CLK_I,
  input wire logic        NRST_I,
  input wire logic [15:0] CTL_I,
  input wire logic [7:0]  FLAG_MODE_I,
  input wire logic [3:0]  SEL_ASSERT_I,
  input wire logic        TIMER_EXPIRED_I,
  input wire logic        SLAVE_SELECT_I,
  input wire logic        SCLK_O,
  input wire logic        DIN_OE_N_O,
  input wire logic [3:0]  FLAG_O,
  input wire logic [3:0]  FLAG_OE_N_O,
  input wire logic        RX_VALID_O,
  input wire logic        BUSY_O,
  input wire logic        MM_ERROR_O
);
  logic       prev_ff, seen_ff, busy_ff, tgl;
  logic [8:0] cnt_ff;
  logic [4:0] tgl_ff;
  // =====================================================================
  // helper counters
  // =====================================================================
  assign tgl = SCLK_O != prev_ff;
  // cycles since the last edge, edges since the word began
  always_ff @(posedge SYS_CLK_I) begin
    prev_ff <= SCLK_O;
    busy_ff <= BUSY_O;
    cnt_ff  <= tgl ? 9'h000 : cnt_ff + 9'h001;
    seen_ff <= NRST_I && BUSY_O && (seen_ff || tgl);
    tgl_ff  <= (BUSY_O && !busy_ff) ? 5'h00 : tgl_ff + {4'h0, tgl};
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  // =====================================================================
  // assertions
  // =====================================================================
  a_half_bit_len: assert property (tgl && seen_ff && BUSY_O
    |-> cnt_ff == {1'b0, CTL_I[15:8]}) else $error("half bit length");
  a_word_edge_count: assert property ($rose(RX_VALID_O) && CTL_I[0]
    |-> ##2 tgl_ff == 5'h10) else $error("edge count per word");
  a_idle_clock_level: assert property
    ((CTL_I[0] && !BUSY_O && $stable(CTL_I))[*3] |-> SCLK_O == CTL_I[1])
    else $error("idle clock level");
  a_mm_error_set: assert property
    ((CTL_I[0] && CTL_I[3] && !SLAVE_SELECT_I)[*4] |-> ##[0:2] MM_ERROR_O)
    else $error("multimaster error missing");
  a_mm_error_clear: assert property ((!CTL_I[0])[*2] |-> !MM_ERROR_O)
    else $error("error kept outside master");
  a_no_start_err: assert property (MM_ERROR_O && !BUSY_O |=> !BUSY_O)
    else $error("start taken in error");
  a_sel_out_drive: assert property ((CTL_I[0] && SEL_ASSERT_I[0] &&
    FLAG_MODE_I[1:0] == spi_port_pkg::FMODE_SEL)[*2]
    |-> !FLAG_OE_N_O[0] && !FLAG_O[0]) else $error("select out");
  a_timer_out: assert property
    ((FLAG_MODE_I[7:6] == spi_port_pkg::FMODE_ALT)[*2]
    |-> !FLAG_OE_N_O[3] && FLAG_O[3] == $past(TIMER_EXPIRED_I))
    else $error("timer output");
  a_master_din_in: assert property ((CTL_I[0] && CTL_I[3])[*2]
    |-> DIN_OE_N_O) else $error("master drives data in");
  a_slv_out_off: assert property ((!CTL_I[0] && CTL_I[5])[*2]
    |-> DIN_OE_N_O) else $error("slave output not disabled");
  a_slave_ignore: assert property
    ((!CTL_I[0] && SLAVE_SELECT_I)[*8] |-> !RX_VALID_O)
    else $error("word taken while unselected");
  a_reset_inputs: assert property ($rose(NRST_I)
    |-> FLAG_OE_N_O == 4'hF && DIN_OE_N_O) else $error("flags after reset");
  c_master_word: cover property ($rose(RX_VALID_O) && CTL_I[0]);
  c_slave_word: cover property ($rose(RX_VALID_O) && !CTL_I[0]);
  c_mm_error: cover property ($rose(MM_ERROR_O));
endmodule : spi_port_checker

bind spi_port spi_port_checker u_chk (.*);

// file: tb/spi_slave_model.sv
// partner: a slave device on the serial link, any of the four formats.
// assumes resolved wires; a released data line floats high.
`timescale 1ns/1ps
module spi_slave_model (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic       first;
  // pull-up owns the line whenever this slave is not selected
  assign miso = sel_n ? 1'b1 : sh[7];
  // a new word loads at select; phase 0 needs bit 7 out at once
  always @(negedge sel_n) begin
    sh    = tx_byte;
    first = cpha;
  end
  // only follows the master clock, never makes one of its own
  always @(sclk) begin
    if (!sel_n && sclk !== 1'bx) begin
      if ((sclk != cpol) ^ cpha) rx_byte = {rx_byte[6:0], mosi};
      else if (first) first = 1'b0;
      else sh = {sh[6:0], 1'b1};
    end
  end
endmodule : spi_slave_model

// file: tb/spi_port_tb.sv
// testbench: master words against a slave model, slave receive,
// flag pin modes and multimaster error of the serial port block.
// assumes 250 MHz system clock; outside master clock of 80 ns period.
`timescale 1ns/1ps
module spi_port_tb;
  logic        clk, nrst, tx_start, timer, bsclk, bsel_n, bmosi, rx_seen;
  logic        sclk_o, sclk_oe_n, dout_o, dout_oe_n, din_o, din_oe_n;
  logic        int_req, rxv, busy, mm, miso;
  logic [15:0] ctl;
  logic [7:0]  tx_data, fmode, sbyte, srx, rx;
  logic [3:0]  fout, fdir, sel_as, flag_in, flag_o, flag_oe_n, flag_io;
  int          fail_count, n_checks, cyc;
  // wire levels: whoever has its enable low owns the line
  wire sclk_w = sclk_oe_n ? bsclk : sclk_o;
  wire dout_w = dout_oe_n ? bmosi : dout_o;
  wire din_w  = din_oe_n ? miso : din_o;
  wire fsel_w = flag_oe_n[0] ? 1'b1 : flag_o[0];

  spi_port dut (.SYS_CLK_I(clk), .NRST_I(nrst), .CTL_I(ctl),
    .TX_DATA_I(tx_data), .TX_START_I(tx_start), .FLAG_MODE_I(fmode),
    .FLAG_OUT_I(fout), .FLAG_DIR_I(fdir), .SEL_ASSERT_I(sel_as),
    .TIMER_EXPIRED_I(timer), .SCLK_I(sclk_w), .SLAVE_SELECT_I(bsel_n),
    .DOUT_PIN_I(dout_w), .DIN_PIN_I(din_w), .FLAG_I(flag_in),
    .SCLK_O(sclk_o), .SCLK_OE_N_O(sclk_oe_n), .DOUT_PIN_O(dout_o),
    .DOUT_OE_N_O(dout_oe_n), .DIN_PIN_O(din_o), .DIN_OE_N_O(din_oe_n),
    .FLAG_O(flag_o), .FLAG_OE_N_O(flag_oe_n), .FLAG_IN_O(flag_io),
    .INT_REQ_O(int_req), .RX_DATA_O(rx), .RX_VALID_O(rxv), .BUSY_O(busy),
    .MM_ERROR_O(mm));

  spi_slave_model u_slave (.sclk(sclk_w), .sel_n(fsel_w), .mosi(dout_w),
    .cpol(ctl[1]), .cpha(ctl[2]), .tx_byte(sbyte), .miso(miso),
    .rx_byte(srx));
  // =====================================================================
  // compare, verdict, clock and timeout
  // =====================================================================
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // the whole run needs well under 10000 cycles
  always @(posedge clk) begin
    cyc++;
    if (rxv === 1'b1) rx_seen <= 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  // =====================================================================
  // scenarios
  // =====================================================================
  // master word: select on flag 0 and 3, a stray start while busy
  task automatic mxfer(input logic [1:0] mode, input logic [7:0] rate);
    logic [7:0] d;
    d = 8'($urandom);
    sbyte = 8'($urandom);
    ctl = {rate, 4'h0, 1'b1, mode, 1'b1};
    repeat (6) @(negedge clk);
    sel_as = 4'h9;
    repeat (4) @(negedge clk);
    chk({7'h0, flag_o[3]}, 8'h00);
    chk({6'h0, sclk_oe_n, dout_oe_n}, 8'h00);
    tx_data = d;
    tx_start = 1'b1;
    @(negedge clk) tx_start = 1'b0;
    @(negedge clk) tx_start = 1'b1;
    @(negedge clk) tx_start = 1'b0;
    rx_seen = 1'b0;
    repeat (600) if (rx_seen !== 1'b1) @(negedge clk);
    chk(rx, sbyte);
    chk(srx, d);
    repeat (6) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
    sel_as = 4'h0;
  endtask : mxfer

  // outside master sends mode 0; sel high selects, dis turns data-in off
  // od makes data-in open drain: a high bit is left to the pull-up
  task automatic sxfer(input logic [7:0] d, input logic sel, dis, od);
    logic [7:0] td;
    logic [7:0] got;
    td = 8'($urandom);
    tx_data = td;
    ctl = {8'h03, 2'h0, dis, od, 4'h8};
    bsclk = 1'b0;
    rx_seen = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h0, sclk_oe_n, dout_oe_n}, 8'h03);
    bsel_n = !sel;
    for (int i = 7; i >= 0; i--) begin
      bmosi = d[i];
      #40 got[i] = din_w;
      bsclk = 1'b1;
      if (i == 3)
        chk({7'h0, din_oe_n}, {7'h0, dis | ~sel | od & td[3]});
      #40 bsclk = 1'b0;
    end
    #40 bsel_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(got, (sel && !dis) ? td : 8'hFF);
    chk({7'h0, rx_seen}, {7'h0, sel});
    if (sel) chk(rx, d);
    chk({7'h0, flag_oe_n[0]}, 8'h01);
  endtask : sxfer

  initial begin
    cyc = $urandom(32'h5a73);
    cyc = 0;
    {nrst, tx_start, timer, rx_seen} = 4'h0;
    {bsclk, bsel_n, bmosi} = 3'h7;
    {ctl, tx_data, fmode, sbyte} = 40'h0;
    {fout, fdir, sel_as} = 12'h000;
    flag_in = 4'hF;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    chk({4'h0, flag_oe_n}, 8'h0F);
    // flag 3 timer out, flag 0 request in, then plain flags
    timer = 1'($urandom);
    fmode = 8'h41;
    flag_in = 4'hE;
    repeat (6) @(negedge clk);
    chk({7'h0, flag_o[3]}, {7'h0, timer});
    chk({7'h0, int_req}, 8'h01);
    chk({4'h0, flag_io}, 8'h0E);
    fmode = 8'h00;
    fdir = 4'h9;
    fout = 4'($urandom);
    repeat (4) @(negedge clk);
    chk({4'h0, flag_oe_n}, 8'h06);
    chk({4'h0, flag_o & 4'h9}, {4'h0, fout & 4'h9});
    chk({7'h0, int_req}, 8'h00);
    fdir = 4'h0;
    fmode = 8'h82;
    for (int i = 0; i < 8; i++)
      mxfer(2'(i), (i == 0) ? 8'h03 : 8'(3 + $urandom_range(9)));
    // another master pulls our select low
    ctl = 16'h0509;
    bsel_n = 1'b0;
    repeat (8) @(negedge clk);
    chk({7'h0, mm}, 8'h01);
    tx_start = 1'b1;
    @(negedge clk) tx_start = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
    bsel_n = 1'b1;
    ctl = 16'h0508;
    repeat (3) @(negedge clk);
    chk({7'h0, mm}, 8'h00);
    sxfer(8'($urandom), 1'b1, 1'b1, 1'b0);
    sxfer(8'hA5, 1'b1, 1'b0, 1'b1);
    sxfer(8'h3C, 1'b0, 1'b0, 1'b0);
    print_verdict();
  end
endmodule : spi_port_tb
